/* File: plc_pkg.sv */
// package: constants and carrier types for the programmable logic cell
`default_nettype none
package plc_pkg;

    localparam int unsigned LUT_INPUTS = 4;
    localparam int unsigned LUT_SIZE   = 16;
    localparam logic        STORE_RST  = 1'b0;
    localparam logic [1:0]  SEL_FFRST  = 2'h0;

    // storage element behaviour
    typedef enum logic [1:0] {
        PLC_FF_D,
        PLC_FF_T,
        PLC_FF_JK,
        PLC_FF_SR
    } plc_ff_e;

    // source of each routing output
    typedef enum logic {
        PLC_OUT_LUT,
        PLC_OUT_REG
    } plc_osel_e;

    // static configuration of one cell
    typedef struct packed {
        logic [LUT_SIZE-1:0] lut_mask;
        plc_ff_e             ff_mode;
        plc_osel_e           sel_row;
        plc_osel_e           sel_col;
        plc_osel_e           sel_local;
        logic                feedback_en;
        logic                packed_en;
        logic                chain_in_en;
    } plc_cfg_s;

    // cluster-wide control signals
    typedef struct packed {
        logic clk_en;
        logic sync_clr;
        logic sync_load;
        logic async_clr;
    } plc_ctl_s;

    // three routing outputs and chain output
    typedef struct packed {
        logic row_out;
        logic col_out;
        logic local_out;
        logic chain_out;
    } plc_out_s;

endpackage : plc_pkg
`default_nettype wire

/* File: plc_cell.sv */
// module: one programmable logic cell with table and storage element
`default_nettype none

// Summary of operation
// - four-input table gives any function
// - storage acts as D, T, JK, SR
// - update on clock edge with enable
// - combinational result bypasses storage unclocked
// - three outputs each pick table or register
// - packing lets table and register split outputs
// - packing with synchronous load is rejected
// - feedback routes register into own table
// - registered and unregistered results together
// - dedicated chain output for cascading
// - chain passes value to next cell
// - asynchronous clear forces zero immediately
// - cluster sync clear and load act
module plc_cell (
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    input  wire plc_pkg::plc_cfg_s          cfg,
    input  wire plc_pkg::plc_ctl_s          ctl,
    input  wire logic [plc_pkg::LUT_INPUTS-1:0] data_in,
    input  wire logic                       load_data,
    input  wire logic                       jk_k,
    input  wire logic                       chain_in,
    output logic                            cfg_error,
    output plc_pkg::plc_out_s               outs
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= plc_pkg::SEL_FFRST;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic q;
    } plc_state_s;

    plc_state_s st_r;
    plc_state_s st_nxt;

    function automatic logic plc_lut(
        input logic [plc_pkg::LUT_SIZE-1:0]   mask,
        input logic [plc_pkg::LUT_INPUTS-1:0] sel
    );
        plc_lut = mask[sel];
    endfunction : plc_lut

    function automatic logic plc_pick(
        input plc_pkg::plc_osel_e s,
        input logic               lut_v,
        input logic               reg_v
    );
        plc_pick = (s == plc_pkg::PLC_OUT_REG) ? reg_v : lut_v;
    endfunction : plc_pick

    // ------------------------------------------------------------
    // table and next state
    // ------------------------------------------------------------
    logic [plc_pkg::LUT_INPUTS-1:0] lut_sel;
    logic                           lut_out;
    logic                           d_src;
    logic                           bad_cfg;

    always_comb begin
        lut_sel = data_in;
        if (cfg.feedback_en) begin
            lut_sel[plc_pkg::LUT_INPUTS-1] = st_r.q;
        end
    end

    assign lut_out = plc_lut(cfg.lut_mask, lut_sel);
    assign bad_cfg = cfg.packed_en & ctl.sync_load;

    always_comb begin
        // packed or chained cells store a source other than the table
        if (cfg.chain_in_en) begin
            d_src = chain_in;
        end else if (cfg.packed_en) begin
            d_src = load_data;
        end else begin
            d_src = lut_out;
        end
    end

    always_comb begin
        st_nxt = st_r;
        if (ctl.clk_en) begin
            if (ctl.sync_clr) begin
                st_nxt.q = plc_pkg::STORE_RST;
            end else if (ctl.sync_load && !bad_cfg) begin
                st_nxt.q = load_data;
            end else begin
                case (cfg.ff_mode)
                    plc_pkg::PLC_FF_D:  st_nxt.q = d_src;
                    plc_pkg::PLC_FF_T:  st_nxt.q = st_r.q ^ d_src;
                    plc_pkg::PLC_FF_JK: st_nxt.q = (d_src & ~st_r.q)
                                                 | (~jk_k & st_r.q);
                    plc_pkg::PLC_FF_SR: st_nxt.q = d_src | (~jk_k & st_r.q);
                    default:            st_nxt.q = st_r.q;
                endcase
            end
        end
    end

    // either clear source empties the register at once, off the clock;
    // one merged clear keeps the register to a single asynchronous input
    logic store_clr_n;
    assign store_clr_n = rst_n & ~ctl.async_clr;

    always_ff @(posedge sys_clk or negedge store_clr_n) begin
        if (!store_clr_n) begin
            st_r.q <= plc_pkg::STORE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        outs.row_out   = plc_pick(cfg.sel_row, lut_out, st_r.q);
        outs.col_out   = plc_pick(cfg.sel_col, lut_out, st_r.q);
        outs.local_out = plc_pick(cfg.sel_local, lut_out, st_r.q);
        outs.chain_out = st_r.q;
    end
    assign cfg_error = bad_cfg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_hold_no_en: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        !ctl.clk_en ##1 !ctl.async_clr |-> $stable(st_r.q))
        else $error("stored value changed with enable low");

    chk_async_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ctl.async_clr |-> st_r.q == plc_pkg::STORE_RST)
        else $error("clear did not force zero");

    chk_d_capture: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && !ctl.sync_clr && !ctl.sync_load
        && cfg.ff_mode == plc_pkg::PLC_FF_D && !cfg.chain_in_en
        && !cfg.packed_en && $stable(cfg)
        ##1 !ctl.async_clr |-> st_r.q == $past(lut_out))
        else $error("d capture wrong");

    chk_toggle_flip: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && !ctl.sync_clr && !ctl.sync_load
        && cfg.ff_mode == plc_pkg::PLC_FF_T && d_src
        ##1 !ctl.async_clr |-> st_r.q != $past(st_r.q))
        else $error("toggle did not flip");

    chk_sync_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && ctl.sync_clr ##1 !ctl.async_clr |-> !st_r.q)
        else $error("sync clear ignored");

    // a refused load must leave the normal function in charge
    chk_pack_reject: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && cfg.packed_en && ctl.sync_load && !ctl.sync_clr
        && !cfg.chain_in_en && cfg.ff_mode == plc_pkg::PLC_FF_T
        ##1 !ctl.async_clr |-> st_r.q == ($past(st_r.q) ^ $past(load_data)))
        else $error("packed load not refused");

    chk_lut_bypass: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cfg.sel_row == plc_pkg::PLC_OUT_LUT && !cfg.feedback_en |->
        outs.row_out == cfg.lut_mask[data_in])
        else $error("row output not table result");

    chk_chain_pass: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && cfg.chain_in_en && !ctl.sync_clr && !ctl.sync_load
        && cfg.ff_mode == plc_pkg::PLC_FF_D
        ##1 !ctl.async_clr |-> outs.chain_out == $past(chain_in))
        else $error("chain value not passed");

    chk_jk_toggle: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && !ctl.sync_clr && !ctl.sync_load
        && cfg.ff_mode == plc_pkg::PLC_FF_JK && d_src && jk_k
        ##1 !ctl.async_clr |-> st_r.q != $past(st_r.q))
        else $error("jk did not toggle");

    chk_sr_reset: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && !ctl.sync_clr && !ctl.sync_load
        && cfg.ff_mode == plc_pkg::PLC_FF_SR && !d_src && jk_k
        ##1 !ctl.async_clr |-> !st_r.q)
        else $error("sr reset ignored");

    chk_sync_load: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        ctl.clk_en && !ctl.sync_clr && ctl.sync_load && !cfg.packed_en
        ##1 !ctl.async_clr |-> st_r.q == $past(load_data))
        else $error("sync load ignored");

    // top table input comes from the register, the rest from the pins
    chk_feedback_in: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cfg.feedback_en && cfg.sel_row == plc_pkg::PLC_OUT_LUT |->
        outs.row_out
        == cfg.lut_mask[{st_r.q, data_in[plc_pkg::LUT_INPUTS-2:0]}])
        else $error("register not fed back into table");

    chk_col_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n || ctl.async_clr)
        cfg.sel_col == plc_pkg::PLC_OUT_REG && !ctl.clk_en ##1
        !ctl.async_clr && cfg.sel_col == plc_pkg::PLC_OUT_REG
        |-> $stable(outs.col_out))
        else $error("registered column output moved");

endmodule : plc_cell
`default_nettype wire

/* File: tb.sv */
// testbench: self-checking bench for the programmable logic cell
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // design and stimulus signals
    // ------------------------------------------------------------
    logic              sys_clk = 1'b0;
    logic              nrst    = 1'b0;
    plc_pkg::plc_cfg_s cfg;
    plc_pkg::plc_ctl_s ctl;
    logic [3:0]        data_in;
    logic              load_data;
    logic              jk_k;
    logic              chain_in;
    logic              cfg_error;
    plc_pkg::plc_out_s outs;
    int                n_fail  = 0;
    int                checked = 0;

    always #4 sys_clk = ~sys_clk;

    plc_cell dut (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg), .ctl(ctl),
        .data_in(data_in), .load_data(load_data), .jk_k(jk_k),
        .chain_in(chain_in), .cfg_error(cfg_error), .outs(outs));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step

    // one clock edge with table source s and second input k
    task automatic ff(input logic s, input logic k, input logic exp);
        cfg.lut_mask = s ? 16'hFFFF : 16'h0000;
        jk_k = k;
        step(1);
        chk(exp, outs.chain_out);
    endtask : ff

    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // table sweep with enable low: register output must not move
    task automatic t_lut();
        cfg.lut_mask = 16'h6996;
        for (int i = 0; i < 16; i++) begin
            data_in = i[3:0];
            step(1);
            chk(^i[3:0], outs.row_out);
            chk(1'b0, outs.col_out);
        end
    endtask : t_lut

    task automatic t_ff();
        ctl.clk_en = 1'b1;
        cfg.ff_mode = plc_pkg::PLC_FF_D;
        ff(1'b1, 1'b0, 1'b1);
        cfg.ff_mode = plc_pkg::PLC_FF_T;
        ff(1'b1, 1'b0, 1'b0);
        ff(1'b0, 1'b0, 1'b0);
        cfg.ff_mode = plc_pkg::PLC_FF_JK;
        ff(1'b1, 1'b0, 1'b1);
        ff(1'b1, 1'b1, 1'b0);
        ff(1'b0, 1'b0, 1'b0);
        cfg.ff_mode = plc_pkg::PLC_FF_SR;
        ff(1'b1, 1'b1, 1'b1);
        ff(1'b0, 1'b0, 1'b1);
        ff(1'b0, 1'b1, 1'b0);
        cfg.ff_mode = plc_pkg::PLC_FF_D;
        ff(1'b1, 1'b0, 1'b1);
        ctl.clk_en = 1'b0;
        ff(1'b0, 1'b0, 1'b1);
        chk(1'b0, outs.row_out);
        chk(1'b1, outs.local_out);
    endtask : t_ff

    task automatic t_clr();
        ctl.clk_en = 1'b1;
        ctl.async_clr = 1'b1;
        #1 chk(1'b0, outs.chain_out);
        step(1);
        ctl.async_clr = 1'b0;
        ff(1'b1, 1'b0, 1'b1);
        ctl.sync_clr = 1'b1;
        ff(1'b1, 1'b0, 1'b0);
        ctl.sync_clr = 1'b0;
        ctl.sync_load = 1'b1;
        load_data = 1'b1;
        ff(1'b0, 1'b0, 1'b1);
        load_data = 1'b0;
        ff(1'b1, 1'b0, 1'b0);
    endtask : t_clr

    task automatic t_pack();
        cfg.packed_en = 1'b1;
        load_data = 1'b1;
        #1 chk(1'b1, cfg_error);
        ff(1'b0, 1'b0, 1'b1);
        cfg.ff_mode = plc_pkg::PLC_FF_T;
        ff(1'b0, 1'b0, 1'b0);
        cfg.ff_mode = plc_pkg::PLC_FF_D;
        ctl.sync_load = 1'b0;
        load_data = 1'b0;
        ff(1'b1, 1'b0, 1'b0);
        chk(1'b1, outs.row_out);
        chk(1'b0, outs.local_out);
        chk(1'b0, cfg_error);
        cfg.packed_en = 1'b0;
    endtask : t_pack

    task automatic t_chain_fb();
        cfg.chain_in_en = 1'b1;
        chain_in = 1'b1;
        ff(1'b0, 1'b0, 1'b1);
        chain_in = 1'b0;
        ff(1'b1, 1'b0, 1'b0);
        cfg.chain_in_en = 1'b0;
        cfg.feedback_en = 1'b1;
        cfg.lut_mask = 16'h00FF;
        data_in = 4'h8;
        step(1);
        chk(1'b1, outs.chain_out);
        step(1);
        chk(1'b0, outs.chain_out);
    endtask : t_chain_fb

    initial begin
        cfg = '0;
        ctl = '0;
        data_in = 4'h0;
        load_data = 1'b0;
        jk_k = 1'b0;
        chain_in = 1'b0;
        cfg.sel_col = plc_pkg::PLC_OUT_REG;
        cfg.sel_local = plc_pkg::PLC_OUT_REG;
        step(16);
        nrst = 1'b1;
        step(3);
        t_lut();
        t_ff();
        t_clr();
        t_pack();
        t_chain_fb();
        summarize();
    end

    // watchdog: a run that overstays counts as a mismatch
    initial begin
        step(2000);
        n_fail++;
        summarize();
    end
endmodule : tb
`default_nettype wire
